/* File: verif/capture_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module capture_slave
(
   input  wire logic sclk,
   input  wire logic data,
   input  wire logic sel,
   input  wire logic pol
);
   logic [31:0] sh;
   int          nb = 0;
   logic [31:0] words[$];
   // Samples on the rising edge while selected
   always @(posedge sclk) if (sel === pol)
   begin
      sh = {sh[30:0], data};
      nb++;
      if (nb % 32 == 0) words.push_back(sh);
   end
endmodule : capture_slave
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        ref_clk = 0, sys_rst = 1, strobe = 0, en = 0, spi = 0;
   logic [7:0]  cfg = 8'h00;
   logic [23:0] s[16];
   logic        sclk, sd, sel, busy;
   int          errors = 0, total_checks = 0;
   always #2.5 ref_clk = ~ref_clk;
   capture_stream_master DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .capture_port_config(cfg), .capture_port_enable(en), .spi_mode_active(spi),
      .sample_strobe(strobe), .phase_a_current_sample(s[0]), .phase_a_voltage_sample(s[1]),
      .phase_b_current_sample(s[2]), .phase_b_voltage_sample(s[3]),
      .phase_c_current_sample(s[4]), .phase_c_voltage_sample(s[5]),
      .neutral_current_sample(s[6]), .phase_a_apparent_power(s[7]),
      .phase_b_apparent_power(s[8]), .phase_c_apparent_power(s[9]),
      .phase_a_active_power(s[10]), .phase_b_active_power(s[11]),
      .phase_c_active_power(s[12]), .phase_a_reactive_power(s[13]),
      .phase_b_reactive_power(s[14]), .phase_c_reactive_power(s[15]),
      .capture_serial_clock(sclk), .capture_data_out(sd), .capture_select_out(sel),
      .transfer_busy(busy));
   capture_slave far_end (.sclk(sclk), .data(sd), .sel(sel), .pol(cfg[5]));
   // ==================================================================
   // Tasks
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic conclude();
      if (errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic pulse();
      @(posedge ref_clk) #1 strobe = 1;
      @(posedge ref_clk) #1 strobe = 0;
   endtask : pulse
   // Strobe while the port may not run
   task automatic refused(logic e, logic m);
      en = e;
      spi = m;
      pulse();
      #10 check("busy while off", 0, busy);
      check("select idle", 1, sel);
   endtask : refused
   // One transfer: words, order, duration and idle levels afterwards
   task automatic xfer(logic [7:0] c, int first, int n, int cyc);
      int t = 0;
      cfg = c;
      en = 1;
      spi = 0;
      far_end.words.delete();
      pulse();
      while (busy !== 1'b0 && t < 60000)
      begin
         #5 t++;
         strobe = (t == 40);
      end
      if (t == 60000)
      begin
         errors++;
         conclude();
      end
      check("busy cycles", 1, t >= cyc && t <= cyc + 3);
      check("word count", n, far_end.words.size());
      for (int i = 0; i < n; i++)
         check("word", {{8{s[first+i][23]}}, s[first+i]}, far_end.words[i]);
      #20 check("idle pins", {2'b11, ~c[5]}, {sclk, sd, sel});
   endtask : xfer
   initial
   begin
      foreach (s[i]) s[i] = {i[0], 23'(i * 23'h1_1111)};
      repeat (10) @(posedge ref_clk);
      #1 check("reset pins", 3'b111, {sclk, sd, sel});
      sys_rst = 0;
      refused(0, 0);
      refused(1, 1);
      xfer(8'h08, 0, 7, 5600);
      xfer(8'h37, 7, 9, 26650);
      xfer(8'h9c, 0, 16, 15425);
      conclude();
   end
endmodule : tb_top
`default_nettype wire

/* File: verilog/capture_stream_master.sv */
`timescale 1ns/100ps
`default_nettype none
module capture_stream_master
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic [7:0]  capture_port_config,
   input  wire logic        capture_port_enable,
   input  wire logic        spi_mode_active,
   input  wire logic        sample_strobe,
   input  wire logic [23:0] phase_a_current_sample,
   input  wire logic [23:0] phase_a_voltage_sample,
   input  wire logic [23:0] phase_b_current_sample,
   input  wire logic [23:0] phase_b_voltage_sample,
   input  wire logic [23:0] phase_c_current_sample,
   input  wire logic [23:0] phase_c_voltage_sample,
   input  wire logic [23:0] neutral_current_sample,
   input  wire logic [23:0] phase_a_apparent_power,
   input  wire logic [23:0] phase_b_apparent_power,
   input  wire logic [23:0] phase_c_apparent_power,
   input  wire logic [23:0] phase_a_active_power,
   input  wire logic [23:0] phase_b_active_power,
   input  wire logic [23:0] phase_c_active_power,
   input  wire logic [23:0] phase_a_reactive_power,
   input  wire logic [23:0] phase_b_reactive_power,
   input  wire logic [23:0] phase_c_reactive_power,
   output logic             capture_serial_clock,
   output logic             capture_data_out,
   output logic             capture_select_out,
   output logic             transfer_busy
);
   // ======================================================================
   // Declarations
   // ======================================================================
   localparam int GAP_FAST_CYCLES = capture_stream_pkg::GAP_PERIODS
                                    * capture_stream_pkg::PERIOD_FAST;

   stream_pipe_if pipe ();

   capture_stream_pkg::link_state_t                 state, next_state;
   logic [capture_stream_pkg::SAMPLE_W-1:0]         sample_in [capture_stream_pkg::NUM_WORDS];
   logic [capture_stream_pkg::SAMPLE_W-1:0]         snap      [capture_stream_pkg::NUM_WORDS];
   logic [capture_stream_pkg::SAMPLE_W-1:0]         next_snap [capture_stream_pkg::NUM_WORDS];
   logic [capture_stream_pkg::IDX_W-1:0]            word_idx, next_word_idx;
   logic [capture_stream_pkg::BIT_W-1:0]            bit_idx, next_bit_idx;
   logic [2:0]                                      gap_cnt, next_gap_cnt;
   logic                                            shifting, next_shifting;
   logic                                            run, next_run;
   logic                                            slow_q, next_slow_q;
   logic                                            size8_q, next_size8_q;
   logic                                            gap_q, next_gap_q;
   logic                                            pol_q, next_pol_q;
   logic [1:0]                                      set_q, next_set_q;
   logic                                            next_sclk;
   logic                                            next_data;
   logic                                            next_select;
   logic                                            pol_use;
   logic                                            port_active;
   logic                                            start;
   logic                                            load;
   logic                                            pkg_end;
   logic [capture_stream_pkg::WORD_W-1:0]           cur_word;
   logic [8:0]                                      gap_cycles;
   logic [capture_stream_pkg::CNT_W-1:0]            low_run;

   // ======================================================================
   // Helpers
   // ======================================================================
   sclk_divider u_divider
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .pipe    (pipe)
   );

   word_set_decoder u_decoder
   (
      .pipe (pipe)
   );

   assign pipe.run      = run;
   assign pipe.slow_sel = slow_q;
   // While idle the live field picks the first word of the next transfer
   assign pipe.word_set = (state == capture_stream_pkg::ST_IDLE)
                          ? capture_port_config[capture_stream_pkg::CFG_SET_MSB:
                                                capture_stream_pkg::CFG_SET_LSB]
                          : set_q;

   // Transmit order of the sample and power words
   assign sample_in[0]  = phase_a_current_sample;
   assign sample_in[1]  = phase_a_voltage_sample;
   assign sample_in[2]  = phase_b_current_sample;
   assign sample_in[3]  = phase_b_voltage_sample;
   assign sample_in[4]  = phase_c_current_sample;
   assign sample_in[5]  = phase_c_voltage_sample;
   assign sample_in[6]  = neutral_current_sample;
   assign sample_in[7]  = phase_a_apparent_power;
   assign sample_in[8]  = phase_b_apparent_power;
   assign sample_in[9]  = phase_c_apparent_power;
   assign sample_in[10] = phase_a_active_power;
   assign sample_in[11] = phase_b_active_power;
   assign sample_in[12] = phase_c_active_power;
   assign sample_in[13] = phase_a_reactive_power;
   assign sample_in[14] = phase_b_reactive_power;
   assign sample_in[15] = phase_c_reactive_power;

   assign port_active = capture_port_enable && !spi_mode_active;
   // A strobe during a running transfer is dropped
   assign start       = sample_strobe && port_active
                        && (state == capture_stream_pkg::ST_IDLE);
   assign load        = start;
   assign cur_word    = {{(capture_stream_pkg::WORD_W - capture_stream_pkg::SAMPLE_W)
                          {snap[word_idx][capture_stream_pkg::SAMPLE_W-1]}},
                         snap[word_idx]};
   assign pkg_end     = gap_q && (size8_q ? (bit_idx[2:0] == 3'h0)
                                          : (bit_idx == '0));
   assign pol_use     = (state == capture_stream_pkg::ST_IDLE)
                        ? capture_port_config[capture_stream_pkg::CFG_POLARITY] : pol_q;

   // ======================================================================
   // Snapshot of the words for one transfer
   // ======================================================================
   genvar gi;
   generate
      for (gi = 0; gi < capture_stream_pkg::NUM_WORDS; gi = gi + 1)
      begin : g_snap
         always_comb
         begin
            next_snap[gi] = load ? sample_in[gi] : snap[gi];
         end

         always_ff @(posedge ref_clk or posedge sys_rst)
         begin
            if (sys_rst)
               snap[gi] <= '0;
            else if (clk_en)
               snap[gi] <= next_snap[gi];
         end
      end
   endgenerate

   // ======================================================================
   // Transfer sequencer
   // ======================================================================
   always_comb
   begin
      next_state    = state;
      next_word_idx = word_idx;
      next_bit_idx  = bit_idx;
      next_gap_cnt  = gap_cnt;
      next_shifting = shifting;
      next_run      = run;
      next_slow_q   = slow_q;
      next_size8_q  = size8_q;
      next_gap_q    = gap_q;
      next_pol_q    = pol_q;
      next_set_q    = set_q;
      next_data     = capture_data_out;
      if (!port_active)
      begin
         next_state    = capture_stream_pkg::ST_IDLE;
         next_shifting = 1'b0;
         next_run      = 1'b0;
         next_data     = 1'b1;
      end
      else
      begin
         unique case (state)
            capture_stream_pkg::ST_IDLE:
            begin
               if (start)
               begin
                  // Bits 7:6 of the configuration are never looked at
                  next_slow_q   = capture_port_config[capture_stream_pkg::CFG_CLK_SEL];
                  next_size8_q  = capture_port_config[capture_stream_pkg::CFG_PKG_SIZE];
                  next_gap_q    = capture_port_config[capture_stream_pkg::CFG_GAP_EN];
                  next_pol_q    = capture_port_config[capture_stream_pkg::CFG_POLARITY];
                  next_set_q    = pipe.word_set;
                  next_word_idx = pipe.first_idx;
                  next_bit_idx  = capture_stream_pkg::BIT_MSB;
                  next_run      = 1'b1;
                  next_state    = capture_stream_pkg::ST_SHIFT;
               end
            end
            capture_stream_pkg::ST_SHIFT:
            begin
               if (pipe.period_tick)
               begin
                  next_shifting = 1'b1;
                  next_data     = cur_word[bit_idx];
                  next_bit_idx  = bit_idx - 1'b1;
                  if (bit_idx == '0 && word_idx == pipe.last_idx)
                     next_state = capture_stream_pkg::ST_TAIL;
                  else
                  begin
                     if (bit_idx == '0)
                        next_word_idx = word_idx + 1'b1;
                     if (pkg_end)
                     begin
                        next_gap_cnt = '0;
                        next_state   = capture_stream_pkg::ST_GAP;
                     end
                  end
               end
            end
            capture_stream_pkg::ST_GAP:
            begin
               if (pipe.period_tick)
               begin
                  next_shifting = 1'b0;
                  next_gap_cnt  = gap_cnt + 1'b1;
                  if (gap_cnt == capture_stream_pkg::GAP_LAST)
                     next_state = capture_stream_pkg::ST_SHIFT;
               end
            end
            capture_stream_pkg::ST_TAIL:
            begin
               if (pipe.period_tick)
               begin
                  next_shifting = 1'b0;
                  next_run      = 1'b0;
                  next_data     = 1'b1;
                  next_state    = capture_stream_pkg::ST_IDLE;
               end
            end
         endcase
      end
      next_sclk   = !(next_shifting && pipe.low_phase);
      next_select = next_shifting ? pol_use : !pol_use;
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state                <= capture_stream_pkg::ST_IDLE;
         word_idx             <= '0;
         bit_idx              <= '0;
         gap_cnt              <= '0;
         shifting             <= 1'b0;
         run                  <= 1'b0;
         slow_q               <= 1'b0;
         size8_q              <= 1'b0;
         gap_q                <= 1'b0;
         pol_q                <= 1'b0;
         set_q                <= capture_stream_pkg::SET_ALL;
         capture_serial_clock <= 1'b1;
         capture_data_out     <= 1'b1;
         capture_select_out   <= 1'b1;
         transfer_busy        <= 1'b0;
      end
      else if (clk_en)
      begin
         state                <= next_state;
         word_idx             <= next_word_idx;
         bit_idx              <= next_bit_idx;
         gap_cnt              <= next_gap_cnt;
         shifting             <= next_shifting;
         run                  <= next_run;
         slow_q               <= next_slow_q;
         size8_q              <= next_size8_q;
         gap_q                <= next_gap_q;
         pol_q                <= next_pol_q;
         set_q                <= next_set_q;
         capture_serial_clock <= next_sclk;
         capture_data_out     <= next_data;
         capture_select_out   <= next_select;
         transfer_busy        <= (next_state != capture_stream_pkg::ST_IDLE);
      end
   end

   // ======================================================================
   // Checks
   // ======================================================================
   // Low run of the serial clock, and idle cycles since the last package bit
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         gap_cycles <= '0;
         low_run    <= '0;
      end
      else if (clk_en)
      begin
         low_run <= capture_serial_clock ? '0 : low_run + 1'b1;
         if (shifting || state == capture_stream_pkg::ST_IDLE)
            gap_cycles <= '0;
         else if (gap_cycles != '1)
            gap_cycles <= gap_cycles + 1'b1;
      end
   end

   chk_disabled_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!port_active && clk_en) |=> (state == capture_stream_pkg::ST_IDLE))
      else $error("transfer running while port disabled");
   chk_first_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (start && clk_en) |=> (word_idx == $past(pipe.first_idx)))
      else $error("wrong first word for word set");
   chk_word_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == capture_stream_pkg::ST_SHIFT && pipe.period_tick && bit_idx == '0
       && word_idx != pipe.last_idx && clk_en)
      |=> (word_idx == $past(word_idx) + 4'h1))
      else $error("words not sent in order");
   chk_sign_bits: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == capture_stream_pkg::ST_SHIFT && pipe.period_tick && bit_idx >= 5'd24
       && clk_en) |=> (capture_data_out == $past(snap[word_idx][23])))
      else $error("upper bits not sign extension");
   chk_data_on_fall: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ($changed(capture_data_out) && shifting) |-> $fell(capture_serial_clock))
      else $error("data changed away from falling edge");
   chk_fast_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ($rose(capture_serial_clock) && !slow_q && clk_en) |-> (low_run == 6'h0c))
      else $error("fast serial clock low phase wrong");
   chk_gap_length: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ($rose(shifting) && gap_cycles > 9'd1 && !slow_q)
      |-> (gap_cycles == 9'(GAP_FAST_CYCLES)))
      else $error("gap is not seven clock periods");
   chk_select_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == capture_stream_pkg::ST_SHIFT && shifting) |-> (capture_select_out == pol_q))
      else $error("select not active during package");
   chk_idle_pins: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == capture_stream_pkg::ST_IDLE && $past(state) == capture_stream_pkg::ST_IDLE)
      |-> (capture_serial_clock && capture_data_out))
      else $error("idle pins not high");
   chk_skip_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (sample_strobe && state != capture_stream_pkg::ST_IDLE && !pipe.period_tick && clk_en)
      |=> ($stable(word_idx) && $stable(bit_idx)))
      else $error("strobe disturbed running transfer");
endmodule : capture_stream_master
`default_nettype wire

/* File: verilog/capture_stream_pkg.sv */
package capture_stream_pkg;

   // ======================================================================
   // Clocking
   // ======================================================================
   localparam int REF_CLK_HZ     = 200_000_000;
   localparam int SCLK_FAST_HZ   = 8_000_000;
   localparam int SCLK_SLOW_HZ   = 4_000_000;
   localparam int PERIOD_FAST    = REF_CLK_HZ / SCLK_FAST_HZ;
   localparam int PERIOD_SLOW    = REF_CLK_HZ / SCLK_SLOW_HZ;
   localparam int CNT_W          = 6;
   localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(PERIOD_FAST - 1);
   localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(PERIOD_SLOW - 1);
   localparam logic [CNT_W-1:0] FAST_LOW  = CNT_W'(PERIOD_FAST / 2);
   localparam logic [CNT_W-1:0] SLOW_LOW  = CNT_W'(PERIOD_SLOW / 2);

   // ======================================================================
   // Configuration register fields
   // ======================================================================
   localparam int          CFG_W          = 8;
   localparam logic [7:0]  CFG_RESET      = 8'h00;
   localparam int          CFG_CLK_SEL    = 0;
   localparam int          CFG_PKG_SIZE   = 1;
   localparam int          CFG_GAP_EN     = 2;
   localparam int          CFG_SET_LSB    = 3;
   localparam int          CFG_SET_MSB    = 4;
   localparam int          CFG_POLARITY   = 5;

   localparam logic [1:0]  SET_ALL        = 2'h0;
   localparam logic [1:0]  SET_SAMPLES    = 2'h1;
   localparam logic [1:0]  SET_POWERS     = 2'h2;
   localparam logic [1:0]  SET_RESERVED   = 2'h3;

   // ======================================================================
   // Word layout
   // ======================================================================
   localparam int          NUM_WORDS      = 16;
   localparam int          IDX_W          = 4;
   localparam int          SAMPLE_W       = 24;
   localparam int          WORD_W         = 32;
   localparam int          BIT_W          = 5;
   localparam logic [4:0]  BIT_MSB        = 5'h1f;
   localparam logic [3:0]  FIRST_SAMPLE   = 4'h0;
   localparam logic [3:0]  LAST_SAMPLE    = 4'h6;
   localparam logic [3:0]  FIRST_POWER    = 4'h7;
   localparam logic [3:0]  LAST_POWER     = 4'hf;
   localparam int          GAP_PERIODS    = 7;
   localparam logic [2:0]  GAP_LAST       = 3'(GAP_PERIODS - 1);

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_GAP   = 2'b10,
      ST_TAIL  = 2'b11
   } link_state_t;

endpackage : capture_stream_pkg

/* File: verilog/sclk_divider.sv */
`timescale 1ns/100ps
`default_nettype none
module sclk_divider
(
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   stream_pipe_if.divider  pipe
);
   // ======================================================================
   // Period counter
   // ======================================================================
   logic [capture_stream_pkg::CNT_W-1:0] cnt;
   logic [capture_stream_pkg::CNT_W-1:0] next_cnt;
   logic [capture_stream_pkg::CNT_W-1:0] last_cnt;
   logic [capture_stream_pkg::CNT_W-1:0] low_cnt;

   always_comb
   begin
      last_cnt = pipe.slow_sel ? capture_stream_pkg::SLOW_LAST : capture_stream_pkg::FAST_LAST;
      low_cnt  = pipe.slow_sel ? capture_stream_pkg::SLOW_LOW : capture_stream_pkg::FAST_LOW;
      if (!pipe.run || cnt == last_cnt)
         next_cnt = '0;
      else
         next_cnt = cnt + 1'b1;
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         cnt <= '0;
      else if (clk_en)
         cnt <= next_cnt;
   end

   // Falling edge of the serial clock opens each period in which a bit is shifted
   assign pipe.period_tick = pipe.run && (cnt == '0);
   assign pipe.low_phase   = cnt < low_cnt;
endmodule : sclk_divider
`default_nettype wire

/* File: verilog/stream_pipe_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface stream_pipe_if;
   logic                                  run;
   logic                                  slow_sel;
   logic                                  period_tick;
   logic                                  low_phase;
   logic [1:0]                            word_set;
   logic [capture_stream_pkg::IDX_W-1:0]  first_idx;
   logic [capture_stream_pkg::IDX_W-1:0]  last_idx;

   modport divider  (input run, slow_sel, output period_tick, low_phase);
   modport selector (input word_set, output first_idx, last_idx);
   modport core     (output run, slow_sel, word_set,
                     input period_tick, low_phase, first_idx, last_idx);
endinterface : stream_pipe_if
`default_nettype wire

/* File: verilog/word_set_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module word_set_decoder
(
   stream_pipe_if.selector pipe
);
   always_comb
   begin
      unique case (pipe.word_set)
         capture_stream_pkg::SET_SAMPLES:
         begin
            pipe.first_idx = capture_stream_pkg::FIRST_SAMPLE;
            pipe.last_idx  = capture_stream_pkg::LAST_SAMPLE;
         end
         capture_stream_pkg::SET_POWERS:
         begin
            pipe.first_idx = capture_stream_pkg::FIRST_POWER;
            pipe.last_idx  = capture_stream_pkg::LAST_POWER;
         end
         capture_stream_pkg::SET_ALL, capture_stream_pkg::SET_RESERVED:
         begin
            pipe.first_idx = capture_stream_pkg::FIRST_SAMPLE;
            pipe.last_idx  = capture_stream_pkg::LAST_POWER;
         end
      endcase
   end
endmodule : word_set_decoder
`default_nettype wire
